// >>> src/ser_pkg.sv
// Shared constants and register map of the status reporting block
package ser_pkg;
   localparam int SER_GRP_W = 16;
   localparam int SER_BYTE_W = 8;

   // Register selector codes on the command port
   typedef enum logic [3:0] {
      SER_QUES_COND = 4'h0,
      SER_QUES_PTR = 4'h1,
      SER_QUES_NTR = 4'h2,
      SER_QUES_EVEN = 4'h3,
      SER_QUES_ENAB = 4'h4,
      SER_OPER_COND = 4'h5,
      SER_OPER_PTR = 4'h6,
      SER_OPER_NTR = 4'h7,
      SER_OPER_EVEN = 4'h8,
      SER_OPER_ENAB = 4'h9,
      SER_STD_EVENT = 4'hA,
      SER_STD_ENABLE = 4'hB,
      SER_STATUS_BYTE = 4'hC,
      SER_SRQ_MASK = 4'hD
   } ser_reg_e;

   // Questionable condition bit positions
   localparam int SER_Q_OVERVOLT = 0;
   localparam int SER_Q_OVERCURR = 1;
   localparam int SER_Q_OVERTEMP = 4;
   localparam int SER_Q_INHIBIT = 9;
   localparam int SER_Q_UNREG = 10;
   localparam logic [15:0] SER_QUES_VALID = 16'h0613;

   // Operation condition bit positions
   localparam int SER_O_WAIT_TRIG = 5;
   localparam int SER_O_CV = 8;
   localparam int SER_O_CC = 10;
   localparam logic [15:0] SER_OPER_VALID = 16'h0520;

   // Standard event bit positions
   localparam int SER_E_OPC = 0;
   localparam int SER_E_QYE = 2;
   localparam int SER_E_DDE = 3;
   localparam int SER_E_EXE = 4;
   localparam int SER_E_CME = 5;
   localparam int SER_E_PON = 7;
   localparam logic [7:0] SER_STD_VALID = 8'hBD;
   localparam logic [7:0] SER_STD_RESET = 8'h80;

   // Status byte bit positions
   localparam int SER_S_QUES = 3;
   localparam int SER_S_MAV = 4;
   localparam int SER_S_ESB = 5;
   localparam int SER_S_MSS = 6;
   localparam int SER_S_OPER = 7;
   localparam logic [7:0] SER_SRE_VALID = 8'hB8;

   localparam logic [15:0] SER_ZERO16 = 16'h0000;
   localparam logic [7:0] SER_ZERO8 = 8'h00;
endpackage : ser_pkg

// >>> src/ser_group_if.sv
// Control and state signals between the top and one status group
interface ser_group_if #(parameter int W = 16);
   logic wr_ptr;
   logic wr_ntr;
   logic wr_ena;
   logic rd_evt;
   logic cls;
   logic [W-1:0] wdata;
   logic [W-1:0] cond;
   logic [W-1:0] ptr;
   logic [W-1:0] ntr;
   logic [W-1:0] ena;
   logic [W-1:0] evt;
   logic summary;

   modport ctrl (
      output wr_ptr, wr_ntr, wr_ena, rd_evt, cls, wdata, cond,
      input ptr, ntr, ena, evt, summary
   );
   modport grp (
      input wr_ptr, wr_ntr, wr_ena, rd_evt, cls, wdata, cond,
      output ptr, ntr, ena, evt, summary
   );
endinterface : ser_group_if

// >>> src/ser_status_group.sv
// One condition / transition filter / event / enable status group
module ser_status_group #(
   parameter int W = 16,
   parameter logic [W-1:0] VALID = '1
) (
   input wire logic clk,
   input wire logic rst,
   ser_group_if.grp gi
);
   import ser_pkg::*;

   logic [W-1:0] prev_reg;
   logic [W-1:0] ptr_reg;
   logic [W-1:0] ntr_reg;
   logic [W-1:0] ena_reg;
   logic [W-1:0] evt_reg;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   logic [W-1:0] arm_set;
   logic [W-1:0] evt_set;
   logic [W-1:0] evt_next;

   if (W < 1) begin : g_bad_width
      $error("ser_status_group: width must be positive");
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= gi.cond;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ptr_reg <= '0;
         ntr_reg <= '0;
         ena_reg <= '0;
      end else begin
         if (gi.wr_ptr) begin
            ptr_reg <= gi.wdata;
         end
         if (gi.wr_ntr) begin
            ntr_reg <= gi.wdata;
         end
         if (gi.wr_ena) begin
            ena_reg <= gi.wdata;
         end
      end
   end

   always_comb begin
      rise = gi.cond & ~prev_reg;
      fall = ~gi.cond & prev_reg;
      // Newly armed filter bit whose condition already sits in the watched state
      arm_set = '0;
      if (gi.wr_ptr) begin
         arm_set = arm_set | (gi.wdata & ~ptr_reg & gi.cond);
      end
      if (gi.wr_ntr) begin
         arm_set = arm_set | (gi.wdata & ~ntr_reg & ~gi.cond);
      end
      evt_set = ((ptr_reg & rise) | (ntr_reg & fall) | arm_set) & VALID;
      // A set in the clearing cycle survives
      evt_next = ((gi.rd_evt || gi.cls) ? '0 : evt_reg) | evt_set;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         evt_reg <= '0;
      end else begin
         evt_reg <= evt_next;
      end
   end

   assign gi.ptr = ptr_reg;
   assign gi.ntr = ntr_reg;
   assign gi.ena = ena_reg;
   assign gi.evt = evt_reg;
   assign gi.summary = |(evt_reg & ena_reg);
endmodule : ser_status_group

// >>> src/ser_status_top.sv
// Status reporting block: questionable, operation, standard event and status byte
// How it works
// - Condition bits mirror live inputs, read-only
// - Rise filter passes 0-to-1 into event bit
// - Fall filter passes 1-to-0 into event bit
// - Events latch; cleared by read or clear-status
// - Questionable summary is bit 3, enable RW
// - Operation group mirrors questionable structure
// - Operation summary drives status byte bit 7
// - Operation bits: trigger 5, CV 8, CC 10
// - Questionable bits: overvoltage 0, overcurrent 1
// - Questionable: overtemp 4, inhibit 9, unregulated 10
// - Standard event bits 0,2,3,4,5,7
// - Status byte bits 3,4,5,6,7
// - Standard event/status byte behave per 488.2
// - Arming filter in watched state sets event
// - Master summary unlatched; status query clears nothing
// - Request latches RQS; serial poll clears it
module ser_status_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic overvoltage_tripped,
   input wire logic overcurrent_tripped,
   input wire logic overtemperature,
   input wire logic remote_inhibit_active,
   input wire logic output_unregulated,
   input wire logic waiting_for_trigger,
   input wire logic constant_voltage_mode,
   input wire logic constant_current_mode,
   input wire logic opc_event,
   input wire logic query_error,
   input wire logic device_error,
   input wire logic execution_error,
   input wire logic command_error,
   input wire logic msg_available,
   input wire ser_pkg::ser_reg_e reg_sel,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ser_pkg::SER_GRP_W-1:0] reg_wdata,
   input wire logic clear_status,
   input wire logic serial_poll,
   output logic [ser_pkg::SER_GRP_W-1:0] rd_data,
   output logic rd_valid,
   output logic [ser_pkg::SER_BYTE_W-1:0] poll_data,
   output logic poll_valid,
   output logic srq
);
   import ser_pkg::*;

   localparam int NPIN = 8;

   // Two-stage synchronisers for the analog status pins
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync1_reg;
   logic [NPIN-1:0] sync2_reg;
   logic [SER_GRP_W-1:0] ques_cond;
   logic [SER_GRP_W-1:0] oper_cond;

   logic [SER_BYTE_W-1:0] esr_reg;
   logic [SER_BYTE_W-1:0] esr_set;
   logic [SER_BYTE_W-1:0] esr_next;
   logic [SER_BYTE_W-1:0] ese_reg;
   logic [SER_BYTE_W-1:0] sre_reg;
   logic [SER_BYTE_W-1:0] stb_core;
   logic [SER_BYTE_W-1:0] stb_query;
   logic esb;
   logic mss;
   logic mss_prev_reg;
   logic rqs_reg;
   logic [SER_GRP_W-1:0] rd_mux;
   logic [SER_GRP_W-1:0] rd_data_reg;
   logic rd_valid_reg;
   logic [SER_BYTE_W-1:0] poll_data_reg;
   logic poll_valid_reg;
   logic wr_ese;
   logic wr_sre;
   logic rd_esr;

   ser_group_if #(.W(SER_GRP_W)) ques_if ();
   ser_group_if #(.W(SER_GRP_W)) oper_if ();

   assign pin_raw = {constant_current_mode, constant_voltage_mode, waiting_for_trigger,
                     output_unregulated, remote_inhibit_active, overtemperature,
                     overcurrent_tripped, overvoltage_tripped};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
      end
   end

   // Unassigned condition bits are tied low and cannot be cleared or written
   always_comb begin
      ques_cond = SER_ZERO16;
      ques_cond[SER_Q_OVERVOLT] = sync2_reg[0];
      ques_cond[SER_Q_OVERCURR] = sync2_reg[1];
      ques_cond[SER_Q_OVERTEMP] = sync2_reg[2];
      ques_cond[SER_Q_INHIBIT] = sync2_reg[3];
      ques_cond[SER_Q_UNREG] = sync2_reg[4];
      oper_cond = SER_ZERO16;
      oper_cond[SER_O_WAIT_TRIG] = sync2_reg[5];
      oper_cond[SER_O_CV] = sync2_reg[6];
      oper_cond[SER_O_CC] = sync2_reg[7];
   end

   // Questionable group wiring
   assign ques_if.cond = ques_cond;
   assign ques_if.wdata = reg_wdata;
   assign ques_if.cls = clear_status;
   assign ques_if.wr_ptr = reg_wr && (reg_sel == SER_QUES_PTR);
   assign ques_if.wr_ntr = reg_wr && (reg_sel == SER_QUES_NTR);
   assign ques_if.wr_ena = reg_wr && (reg_sel == SER_QUES_ENAB);
   assign ques_if.rd_evt = reg_rd && (reg_sel == SER_QUES_EVEN);

   // Operation group: same structure
   assign oper_if.cond = oper_cond;
   assign oper_if.wdata = reg_wdata;
   assign oper_if.cls = clear_status;
   assign oper_if.wr_ptr = reg_wr && (reg_sel == SER_OPER_PTR);
   assign oper_if.wr_ntr = reg_wr && (reg_sel == SER_OPER_NTR);
   assign oper_if.wr_ena = reg_wr && (reg_sel == SER_OPER_ENAB);
   assign oper_if.rd_evt = reg_rd && (reg_sel == SER_OPER_EVEN);

   ser_status_group #(.W(SER_GRP_W), .VALID(SER_QUES_VALID)) u_ques (
      .clk(clk),
      .rst(rst),
      .gi(ques_if.grp)
   );

   ser_status_group #(.W(SER_GRP_W), .VALID(SER_OPER_VALID)) u_oper (
      .clk(clk),
      .rst(rst),
      .gi(oper_if.grp)
   );

   // Standard event register
   assign wr_ese = reg_wr && (reg_sel == SER_STD_ENABLE);
   assign wr_sre = reg_wr && (reg_sel == SER_SRQ_MASK);
   assign rd_esr = reg_rd && (reg_sel == SER_STD_EVENT);

   always_comb begin
      esr_set = SER_ZERO8;
      esr_set[SER_E_OPC] = opc_event;
      esr_set[SER_E_QYE] = query_error;
      esr_set[SER_E_DDE] = device_error;
      esr_set[SER_E_EXE] = execution_error;
      esr_set[SER_E_CME] = command_error;
      esr_next = (rd_esr || clear_status) ? SER_ZERO8 : esr_reg;
      esr_next = (esr_next | esr_set) & SER_STD_VALID;
   end

   // Power-on bit comes up set; only the reset value carries it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         esr_reg <= SER_STD_RESET;
      end else begin
         esr_reg <= esr_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ese_reg <= SER_ZERO8;
         sre_reg <= SER_ZERO8;
      end else begin
         if (wr_ese) begin
            ese_reg <= reg_wdata[SER_BYTE_W-1:0] & SER_STD_VALID;
         end
         // Bit 6 of the mask is meaningless and always reads zero
         if (wr_sre) begin
            sre_reg <= reg_wdata[SER_BYTE_W-1:0] & SER_SRE_VALID;
         end
      end
   end

   // Status byte
   assign esb = |(esr_reg & ese_reg);

   always_comb begin
      stb_core = SER_ZERO8;
      stb_core[SER_S_QUES] = ques_if.summary;
      stb_core[SER_S_MAV] = msg_available;
      stb_core[SER_S_ESB] = esb;
      stb_core[SER_S_OPER] = oper_if.summary;
   end

   assign mss = |(stb_core & sre_reg);

   always_comb begin
      stb_query = stb_core;
      stb_query[SER_S_MSS] = mss;
   end

   // Request latches on a new reason; the poll is the only thing that clears it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mss_prev_reg <= 1'b0;
         rqs_reg <= 1'b0;
      end else begin
         mss_prev_reg <= mss;
         if (mss && !mss_prev_reg) begin
            rqs_reg <= 1'b1;
         end else if (serial_poll) begin
            rqs_reg <= 1'b0;
         end
      end
   end

   assign srq = rqs_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         poll_data_reg <= SER_ZERO8;
         poll_valid_reg <= 1'b0;
      end else begin
         poll_valid_reg <= serial_poll;
         if (serial_poll) begin
            poll_data_reg <= {stb_core[7], rqs_reg, stb_core[5:0]};
         end
      end
   end

   // Register read mux; unmapped selectors read zero
   always_comb begin
      rd_mux = SER_ZERO16;
      unique case (reg_sel)
         SER_QUES_COND: rd_mux = ques_cond;
         SER_QUES_PTR: rd_mux = ques_if.ptr;
         SER_QUES_NTR: rd_mux = ques_if.ntr;
         SER_QUES_EVEN: rd_mux = ques_if.evt;
         SER_QUES_ENAB: rd_mux = ques_if.ena;
         SER_OPER_COND: rd_mux = oper_cond;
         SER_OPER_PTR: rd_mux = oper_if.ptr;
         SER_OPER_NTR: rd_mux = oper_if.ntr;
         SER_OPER_EVEN: rd_mux = oper_if.evt;
         SER_OPER_ENAB: rd_mux = oper_if.ena;
         SER_STD_EVENT: rd_mux = {SER_ZERO8, esr_reg};
         SER_STD_ENABLE: rd_mux = {SER_ZERO8, ese_reg};
         SER_STATUS_BYTE: rd_mux = {SER_ZERO8, stb_query};
         SER_SRQ_MASK: rd_mux = {SER_ZERO8, sre_reg};
         default: rd_mux = SER_ZERO16;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data_reg <= SER_ZERO16;
         rd_valid_reg <= 1'b0;
      end else begin
         rd_valid_reg <= reg_rd;
         if (reg_rd) begin
            rd_data_reg <= rd_mux;
         end
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;
   assign poll_data = poll_data_reg;
   assign poll_valid = poll_valid_reg;

   // Checks
   a_cond_mirror: assert property (@(posedge clk) disable iff (rst)
      ques_cond[SER_Q_OVERTEMP] == $past(overtemperature, 2))
      else $error("questionable condition does not follow pin");

   a_rise_sets_event: assert property (@(posedge clk) disable iff (rst)
      (ques_if.ptr[SER_Q_UNREG] && $rose(ques_cond[SER_Q_UNREG]))
      |=> ques_if.evt[SER_Q_UNREG])
      else $error("rising edge through filter lost");

   a_fall_sets_event: assert property (@(posedge clk) disable iff (rst)
      (oper_if.ntr[SER_O_CV] && $fell(oper_cond[SER_O_CV]))
      |=> oper_if.evt[SER_O_CV])
      else $error("falling edge through filter lost");

   a_blocked_no_event: assert property (@(posedge clk) disable iff (rst)
      (!ques_if.ptr[SER_Q_INHIBIT] && !ques_if.ntr[SER_Q_INHIBIT] && !ques_if.wr_ptr
       && !ques_if.wr_ntr && !ques_if.evt[SER_Q_INHIBIT])
      |=> !ques_if.evt[SER_Q_INHIBIT])
      else $error("event set with both filters off");

   // A read with no filtered edge and no arming write leaves the event word empty
   a_read_clears_event: assert property (@(posedge clk) disable iff (rst)
      (ques_if.rd_evt && !ques_if.wr_ptr && !ques_if.wr_ntr
       && ((ques_if.ptr & ques_cond & ~$past(ques_cond))
           | (ques_if.ntr & ~ques_cond & $past(ques_cond))) == SER_ZERO16)
      |=> ques_if.evt == SER_ZERO16)
      else $error("event survived read without new transition");

   a_event_holds: assert property (@(posedge clk) disable iff (rst)
      (oper_if.evt[SER_O_CV] && !oper_if.rd_evt && !clear_status)
      |=> oper_if.evt[SER_O_CV])
      else $error("event bit dropped without clear");

   a_ques_summary: assert property (@(posedge clk) disable iff (rst)
      stb_query[SER_S_QUES] == |(ques_if.evt & ques_if.ena))
      else $error("questionable summary wrong");

   a_oper_summary: assert property (@(posedge clk) disable iff (rst)
      $rose(oper_if.evt[SER_O_CV]) && oper_if.ena[SER_O_CV]
      |-> stb_core[SER_S_OPER])
      else $error("operation summary missing");

   a_arm_sets_event: assert property (@(posedge clk) disable iff (rst)
      (ques_if.wr_ptr && ques_if.wdata[SER_Q_INHIBIT] && !ques_if.ptr[SER_Q_INHIBIT]
       && ques_cond[SER_Q_INHIBIT]) |=> ques_if.evt[SER_Q_INHIBIT])
      else $error("arming filter did not set event");

   a_mss_live: assert property (@(posedge clk) disable iff (rst)
      mss == |(stb_core & sre_reg & SER_SRE_VALID))
      else $error("master summary mismatch");

   a_rqs_latch: assert property (@(posedge clk) disable iff (rst)
      (mss && !mss_prev_reg) |=> srq ##1 (srq || $past(serial_poll)))
      else $error("request not latched");

   a_poll_clears: assert property (@(posedge clk) disable iff (rst)
      (serial_poll && !(mss && !mss_prev_reg)) |=> !srq ##0 poll_valid)
      else $error("poll did not clear request");

   a_filter_stable: assert property (@(posedge clk) disable iff (rst)
      !ques_if.wr_ntr |=> $stable(ques_if.ntr))
      else $error("filter changed without write");

   a_unassigned_zero: assert property (@(posedge clk) disable iff (rst)
      (ques_if.evt & ~SER_QUES_VALID) == SER_ZERO16
      && (oper_cond & ~SER_OPER_VALID) == SER_ZERO16)
      else $error("unassigned bit set");

   c_ques_event: cover property (@(posedge clk) disable iff (rst)
      $rose(stb_core[SER_S_QUES]));
   c_service_request: cover property (@(posedge clk) disable iff (rst)
      $rose(srq) ##[1:20] serial_poll);
   c_event_read: cover property (@(posedge clk) disable iff (rst)
      ques_if.rd_evt && ques_if.evt != SER_ZERO16);
   c_clear_status: cover property (@(posedge clk) disable iff (rst)
      clear_status && esr_reg != SER_ZERO8);
endmodule : ser_status_top

// >>> verif/ser_ctrl_model.sv
// Bus controller model issuing status register commands and serial polls
module ser_ctrl_model import ser_pkg::*; (
   input wire logic clk,
   output ser_pkg::ser_reg_e reg_sel,
   output logic reg_wr,
   output logic reg_rd,
   output logic [ser_pkg::SER_GRP_W-1:0] reg_wdata,
   output logic clear_status,
   output logic serial_poll,
   input wire logic [ser_pkg::SER_GRP_W-1:0] rd_data,
   input wire logic rd_valid,
   input wire logic [ser_pkg::SER_BYTE_W-1:0] poll_data,
   input wire logic poll_valid
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_sel = SER_QUES_COND;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
      clear_status = 1'b0;
      serial_poll = 1'b0;
   end

   task automatic wr(input ser_reg_e sel, input logic [15:0] d);
      @(posedge clk);
      reg_sel <= sel;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      // Idle data must not look like the last word
      reg_wdata <= ~d;
   endtask : wr

   task automatic rd(input ser_reg_e sel, output logic [15:0] d, output logic v);
      @(posedge clk);
      reg_sel <= sel;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = rd_valid;
      d = rd_data;
   endtask : rd

   task automatic cls();
      @(posedge clk);
      clear_status <= 1'b1;
      @(posedge clk);
      clear_status <= 1'b0;
   endtask : cls

   task automatic poll(output logic [7:0] d, output logic v);
      @(posedge clk);
      serial_poll <= 1'b1;
      @(posedge clk);
      serial_poll <= 1'b0;
      #1;
      v = poll_valid;
      d = poll_data;
   endtask : poll
endmodule : ser_ctrl_model

// >>> verif/status_event_reporting_tb.sv
// Self-checking bench of the status reporting block
module status_event_reporting_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ser_pkg::*;
   localparam int MAX_CYCLES = 3000;
   logic clk, rst, msg_available, srq, reg_wr, reg_rd, clear_status, serial_poll;
   logic rd_valid, poll_valid;
   logic [4:0] q_pins, std_pulse;
   logic [2:0] o_pins;
   ser_reg_e reg_sel;
   logic [15:0] reg_wdata, rd_data;
   logic [7:0] poll_data;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;

   ser_status_top i_ser_status_top (.clk(clk), .rst(rst),
      .overvoltage_tripped(q_pins[0]), .overcurrent_tripped(q_pins[1]),
      .overtemperature(q_pins[2]), .remote_inhibit_active(q_pins[3]),
      .output_unregulated(q_pins[4]), .waiting_for_trigger(o_pins[0]),
      .constant_voltage_mode(o_pins[1]), .constant_current_mode(o_pins[2]),
      .opc_event(std_pulse[0]), .query_error(std_pulse[1]), .device_error(std_pulse[2]),
      .execution_error(std_pulse[3]), .command_error(std_pulse[4]),
      .msg_available(msg_available), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .clear_status(clear_status), .serial_poll(serial_poll),
      .rd_data(rd_data), .rd_valid(rd_valid), .poll_data(poll_data),
      .poll_valid(poll_valid), .srq(srq));

   ser_ctrl_model i_ser_ctrl_model (.clk(clk), .reg_sel(reg_sel), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .clear_status(clear_status),
      .serial_poll(serial_poll), .rd_data(rd_data), .rd_valid(rd_valid),
      .poll_data(poll_data), .poll_valid(poll_valid));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == MAX_CYCLES) begin
         err_total++;
         $display("[FAIL] %0t run did not finish", $time);
         stop_test();
      end
   end

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk16

   task automatic chk1(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s: got %b expected %b", $time, what, got, exp);
      end
   endtask : chk1

   task automatic rd_chk(input ser_reg_e sel, input logic [15:0] exp);
      logic [15:0] d;
      logic v;
      i_ser_ctrl_model.rd(sel, d, v);
      chk1(v, 1'b1, "read valid");
      chk16(d, exp, $sformatf("read of selector %h", sel));
   endtask : rd_chk

   task automatic poll_chk(input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      i_ser_ctrl_model.poll(d, v);
      chk1(v, 1'b1, "poll valid");
      chk16({8'h00, d}, {8'h00, exp}, "poll byte");
      chk1(srq, 1'b0, "request after poll");
   endtask : poll_chk

   // Pin to summary takes three edges; two spare
   task automatic settle();
      repeat (5) @(posedge clk);
   endtask : settle

   task automatic t_reset();
      ser_reg_e rw [8] = '{SER_QUES_PTR, SER_QUES_NTR, SER_QUES_ENAB, SER_OPER_PTR,
         SER_OPER_NTR, SER_OPER_ENAB, SER_STD_ENABLE, SER_SRQ_MASK};
      foreach (rw[i]) rd_chk(rw[i], 16'h0000);
      rd_chk(SER_STD_EVENT, 16'h0080);
      rd_chk(SER_STD_EVENT, 16'h0000);
      rd_chk(SER_STATUS_BYTE, 16'h0000);
      rd_chk(ser_reg_e'(4'hE), 16'h0000);
      chk1(srq, 1'b0, "request at reset");
   endtask : t_reset

   task automatic t_cond();
      logic [15:0] qmap [5] = '{16'h0001, 16'h0002, 16'h0010, 16'h0200, 16'h0400};
      logic [15:0] omap [3] = '{16'h0020, 16'h0100, 16'h0400};
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         q_pins <= 5'(1 << i);
         settle();
         rd_chk(SER_QUES_COND, qmap[i]);
      end
      @(posedge clk);
      q_pins <= 5'h00;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         o_pins <= 3'(1 << i);
         settle();
         rd_chk(SER_OPER_COND, omap[i]);
      end
      @(posedge clk);
      o_pins <= 3'h0;
      settle();
      i_ser_ctrl_model.wr(SER_QUES_COND, 16'hFFFF);
      rd_chk(SER_QUES_COND, 16'h0000);
      rd_chk(SER_QUES_EVEN, 16'h0000);
      rd_chk(SER_OPER_EVEN, 16'h0000);
   endtask : t_cond

   task automatic t_rise();
      i_ser_ctrl_model.wr(SER_QUES_PTR, 16'h0010);
      i_ser_ctrl_model.wr(SER_QUES_ENAB, 16'h0010);
      rd_chk(SER_QUES_PTR, 16'h0010);
      rd_chk(SER_QUES_ENAB, 16'h0010);
      @(posedge clk);
      q_pins <= 5'b00100;
      settle();
      rd_chk(SER_STATUS_BYTE, 16'h0008);
      rd_chk(SER_QUES_EVEN, 16'h0010);
      rd_chk(SER_QUES_EVEN, 16'h0000);
      rd_chk(SER_STATUS_BYTE, 16'h0000);
      @(posedge clk);
      q_pins <= 5'b00000;
      settle();
      rd_chk(SER_QUES_EVEN, 16'h0000);
      i_ser_ctrl_model.wr(SER_QUES_PTR, 16'h0000);
      i_ser_ctrl_model.wr(SER_QUES_ENAB, 16'h0000);
      rd_chk(SER_QUES_PTR, 16'h0000);
   endtask : t_rise

   task automatic t_fall();
      @(posedge clk);
      o_pins <= 3'b010;
      settle();
      i_ser_ctrl_model.wr(SER_OPER_NTR, 16'h0100);
      i_ser_ctrl_model.wr(SER_OPER_ENAB, 16'h0100);
      @(posedge clk);
      o_pins <= 3'b000;
      settle();
      rd_chk(SER_STATUS_BYTE, 16'h0080);
      i_ser_ctrl_model.cls();
      rd_chk(SER_OPER_EVEN, 16'h0000);
      @(posedge clk);
      o_pins <= 3'b010;
      settle();
      rd_chk(SER_OPER_EVEN, 16'h0000);
      @(posedge clk);
      o_pins <= 3'b000;
      settle();
      rd_chk(SER_OPER_EVEN, 16'h0100);
      i_ser_ctrl_model.wr(SER_OPER_NTR, 16'h0000);
      i_ser_ctrl_model.wr(SER_OPER_ENAB, 16'h0000);
   endtask : t_fall

   task automatic t_both();
      i_ser_ctrl_model.wr(SER_QUES_PTR, 16'h0400);
      i_ser_ctrl_model.wr(SER_QUES_NTR, 16'h0400);
      rd_chk(SER_QUES_EVEN, 16'h0400);
      @(posedge clk);
      q_pins <= 5'b10000;
      settle();
      rd_chk(SER_QUES_EVEN, 16'h0400);
      @(posedge clk);
      q_pins <= 5'b00000;
      settle();
      rd_chk(SER_QUES_EVEN, 16'h0400);
      i_ser_ctrl_model.wr(SER_QUES_PTR, 16'h0000);
      i_ser_ctrl_model.wr(SER_QUES_NTR, 16'h0000);
      @(posedge clk);
      q_pins <= 5'b11000;
      settle();
      @(posedge clk);
      q_pins <= 5'b01000;
      settle();
      rd_chk(SER_QUES_EVEN, 16'h0000);
      i_ser_ctrl_model.wr(SER_QUES_PTR, 16'h0200);
      rd_chk(SER_QUES_EVEN, 16'h0200);
      @(posedge clk);
      q_pins <= 5'b00000;
      i_ser_ctrl_model.wr(SER_QUES_PTR, 16'h0000);
   endtask : t_both

   task automatic t_srq();
      i_ser_ctrl_model.wr(SER_QUES_PTR, 16'h0002);
      i_ser_ctrl_model.wr(SER_QUES_ENAB, 16'h0002);
      i_ser_ctrl_model.wr(SER_SRQ_MASK, 16'h0048);
      rd_chk(SER_SRQ_MASK, 16'h0008);
      @(posedge clk);
      q_pins <= 5'b00010;
      settle();
      chk1(srq, 1'b1, "service request");
      rd_chk(SER_STATUS_BYTE, 16'h0048);
      rd_chk(SER_STATUS_BYTE, 16'h0048);
      poll_chk(8'h48);
      rd_chk(SER_STATUS_BYTE, 16'h0048);
      poll_chk(8'h08);
      @(posedge clk);
      q_pins <= 5'b00000;
      rd_chk(SER_QUES_EVEN, 16'h0002);
      rd_chk(SER_STATUS_BYTE, 16'h0000);
      i_ser_ctrl_model.wr(SER_QUES_PTR, 16'h0000);
      i_ser_ctrl_model.wr(SER_QUES_ENAB, 16'h0000);
   endtask : t_srq

   task automatic t_std();
      @(posedge clk);
      std_pulse <= 5'h1F;
      @(posedge clk);
      std_pulse <= 5'h00;
      rd_chk(SER_STD_EVENT, 16'h003D);
      rd_chk(SER_STD_EVENT, 16'h0000);
      i_ser_ctrl_model.wr(SER_STD_ENABLE, 16'h003C);
      i_ser_ctrl_model.wr(SER_SRQ_MASK, 16'h0020);
      rd_chk(SER_STD_ENABLE, 16'h003C);
      @(posedge clk);
      std_pulse <= 5'h10;
      @(posedge clk);
      std_pulse <= 5'h00;
      settle();
      rd_chk(SER_STATUS_BYTE, 16'h0060);
      poll_chk(8'h60);
      i_ser_ctrl_model.cls();
      rd_chk(SER_STD_EVENT, 16'h0000);
      @(posedge clk);
      msg_available <= 1'b1;
      rd_chk(SER_STATUS_BYTE, 16'h0010);
   endtask : t_std

   initial begin
      rst = 1'b1;
      q_pins = 5'h00;
      o_pins = 3'h0;
      std_pulse = 5'h00;
      msg_available = 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_cond();
      t_rise();
      t_fall();
      t_both();
      t_srq();
      t_std();
      stop_test();
   end
endmodule : status_event_reporting_tb
